// ### rtl/swc_pkg.sv
package swc_pkg;
   // ==========================================================
   // Register map (byte addresses, one 32-bit word apart)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_MODE   = 4'h4;
   localparam logic [3:0] ADDR_WCFG   = 4'h8;
   localparam logic [3:0] ADDR_STAT   = 4'hC;
   // ==========================================================
   // Field layout
   localparam int         NUM_WAKE    = 10;
   localparam int         DBC_W       = 16;
   localparam int         KEY_LSB     = 24;
   localparam logic [7:0] CTRL_KEY    = 8'hA5;
   localparam int         CMD_BIT     = 0;
   localparam int         WEN_LSB     = 0;
   localparam int         WPOL_LSB    = 16;
   localparam int         SEC_BIT     = 16;
   // ==========================================================
   // Reset values and timing
   localparam logic [NUM_WAKE-1:0] WEN_RST  = 10'h000;
   localparam logic [NUM_WAKE-1:0] WPOL_RST = 10'h000;
   localparam logic [DBC_W-1:0]    DBC_RST  = 16'h0000;
   localparam logic [1:0]          OFF_DELAY = 2'h2;
   typedef enum logic [1:0] {
      SWC_ON    = 2'b00,
      SWC_ARMED = 2'b01,
      SWC_OFF   = 2'b10
   } swc_state_t;
endpackage : swc_pkg

// ### rtl/swc_edge.sv
`timescale 1ns/1ps
module swc_edge (
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic pin,
   input  wire logic enable,
   input  wire logic polarity,
   output logic      hit,
   output logic      change
);
   logic prev_ff;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= pin;
      end
   end
   // Polarity 1 picks rising edge, 0 falling edge
   assign hit    = enable & (polarity ? (pin & ~prev_ff) : (~pin & prev_ff));
   assign change = enable & (pin ^ prev_ff);
endmodule : swc_edge

// ### rtl/swc_top.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Block runs on one always-running slow clock, never gated by anything.
// - Keyed shutdown command raises power-off output exactly two cycles after write.
// - Control writes without correct key field are ignored completely.
// - Backup pins, dedicated pin or security event can each cause wakeup.
// - Each wake pin has enable and polarity bit selecting rising or falling edge; the security event has neither.
// - Detected edge starts debounce counter; reaching programmed count releases power-off.
// - A change on an enabled input before count completes zeroes counter; a programmed edge restarts it, any other change stops it.
// - One shared debounce counter serves every enabled wakeup input.
// - Per-input status bit sets on detection; reading status clears all bits that see no event in the same cycle.
module swc_top (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic        dedicated_wake_pin,
   input  wire logic [8:0]  backup_wake_pin,
   input  wire logic        security_event,
   output logic             power_off_out
);
   // ==========================================================
   // Registers
   // Clock is the free-running slow clock; no gating anywhere in this block
   logic [swc_pkg::NUM_WAKE-1:0] wake_input_enable_bit_ff;
   logic [swc_pkg::NUM_WAKE-1:0] wake_input_polarity_bit_ff;
   logic [swc_pkg::DBC_W-1:0]    wake_debounce_count_ff;
   logic [swc_pkg::NUM_WAKE-1:0] wake_input_status_bit_ff;
   logic                         sec_status_ff;
   logic [swc_pkg::DBC_W-1:0]    dbc_cnt_ff;
   logic                         dbc_run_ff;
   logic [1:0]                   dly_ff;
   swc_pkg::swc_state_t          state_ff;
   logic                         power_off_ff;
   logic [31:0]                  rdata_ff;
   logic [swc_pkg::NUM_WAKE-1:0] pins;
   logic [swc_pkg::NUM_WAKE-1:0] hit;
   logic [swc_pkg::NUM_WAKE-1:0] chg;
   logic                         any_hit;
   logic                         any_chg;
   logic                         cmd_ok;
   logic                         dbc_done;

   assign pins = {backup_wake_pin, dedicated_wake_pin};

   // ==========================================================
   // Edge detectors, one per wake input
   genvar gi;
   generate
      for (gi = 0; gi < swc_pkg::NUM_WAKE; gi++) begin : g_edge
         swc_edge u_edge (
            .clk_sys  (clk_sys),
            .rstn     (rstn),
            .pin      (pins[gi]),
            .enable   (wake_input_enable_bit_ff[gi]),
            .polarity (wake_input_polarity_bit_ff[gi]),
            .hit      (hit[gi]),
            .change   (chg[gi])
         );
      end
   endgenerate

   // Merge all enabled inputs into one detector feed
   assign any_hit = |hit;
   assign any_chg = |chg;

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wake_input_enable_bit_ff   <= swc_pkg::WEN_RST;
         wake_input_polarity_bit_ff <= swc_pkg::WPOL_RST;
      end else if (reg_wr && reg_addr == swc_pkg::ADDR_WCFG) begin
         wake_input_enable_bit_ff   <= reg_wdata[swc_pkg::WEN_LSB +: swc_pkg::NUM_WAKE];
         wake_input_polarity_bit_ff <= reg_wdata[swc_pkg::WPOL_LSB +: swc_pkg::NUM_WAKE];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wake_debounce_count_ff <= swc_pkg::DBC_RST;
      end else if (reg_wr && reg_addr == swc_pkg::ADDR_MODE) begin
         wake_debounce_count_ff <= reg_wdata[swc_pkg::DBC_W-1:0];
      end
   end

   // ==========================================================
   // Shutdown command, key protected
   assign cmd_ok = reg_wr && reg_addr == swc_pkg::ADDR_CTRL
                   && reg_wdata[swc_pkg::KEY_LSB +: 8] == swc_pkg::CTRL_KEY
                   && reg_wdata[swc_pkg::CMD_BIT];

   // ==========================================================
   // Debounce counter, shared by all inputs
   // A wrong-way change restarts nothing: it aborts; only a fresh programmed edge restarts
   assign dbc_done = dbc_run_ff && (dbc_cnt_ff >= wake_debounce_count_ff);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dbc_cnt_ff <= swc_pkg::DBC_RST;
         dbc_run_ff <= 1'b0;
      end else if (any_hit) begin
         dbc_cnt_ff <= swc_pkg::DBC_RST;
         dbc_run_ff <= 1'b1;
      end else if (any_chg && dbc_run_ff) begin
         dbc_cnt_ff <= swc_pkg::DBC_RST;
         dbc_run_ff <= 1'b0;
      end else if (dbc_done) begin
         dbc_cnt_ff <= swc_pkg::DBC_RST;
         dbc_run_ff <= 1'b0;
      end else if (dbc_run_ff) begin
         dbc_cnt_ff <= dbc_cnt_ff + 16'h0001;
      end
   end

   // ==========================================================
   // Power state machine
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_ff     <= swc_pkg::SWC_ON;
         dly_ff       <= 2'h0;
         power_off_ff <= 1'b0;
      end else begin
         case (state_ff)
            swc_pkg::SWC_ON: begin
               if (cmd_ok) begin
                  state_ff <= swc_pkg::SWC_ARMED;
                  dly_ff   <= 2'h1;
               end
            end
            swc_pkg::SWC_ARMED: begin
               // Output and state move on one edge so they can never disagree
               if (dly_ff == swc_pkg::OFF_DELAY) begin
                  state_ff     <= swc_pkg::SWC_OFF;
                  power_off_ff <= 1'b1;
               end else begin
                  dly_ff <= dly_ff + 2'h1;
               end
            end
            swc_pkg::SWC_OFF: begin
               // Wake sources only matter while powered down
               if (dbc_done || security_event) begin
                  power_off_ff <= 1'b0;
                  state_ff     <= swc_pkg::SWC_ON;
               end
            end
            default: begin
               state_ff     <= swc_pkg::SWC_ON;
               power_off_ff <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Status, clear on read; a same-cycle event wins over the clear
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wake_input_status_bit_ff <= {swc_pkg::NUM_WAKE{1'b0}};
         sec_status_ff            <= 1'b0;
      end else begin
         if (reg_rd && reg_addr == swc_pkg::ADDR_STAT) begin
            wake_input_status_bit_ff <= hit;
            sec_status_ff            <= security_event;
         end else begin
            wake_input_status_bit_ff <= wake_input_status_bit_ff | hit;
            sec_status_ff            <= sec_status_ff | security_event;
         end
      end
   end

   // ==========================================================
   // Read port
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata_ff <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            swc_pkg::ADDR_MODE: rdata_ff <= {16'h0000, wake_debounce_count_ff};
            swc_pkg::ADDR_WCFG: rdata_ff <= {6'h00, wake_input_polarity_bit_ff,
                                             6'h00, wake_input_enable_bit_ff};
            swc_pkg::ADDR_STAT: rdata_ff <= {15'h0000, sec_status_ff,
                                             6'h00, wake_input_status_bit_ff};
            default:            rdata_ff <= 32'h00000000;
         endcase
      end else begin
         rdata_ff <= 32'h00000000;
      end
   end

   assign reg_rdata     = rdata_ff;
   assign power_off_out = power_off_ff;

   // ==========================================================
   // Checks

   // ==========================================================
   // Shutdown sequence
   a_off_two_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
      (cmd_ok && state_ff == swc_pkg::SWC_ON) |-> !power_off_out ##1 !power_off_out
      ##1 !power_off_out ##1 power_off_out)
      else $error("power-off not asserted two cycles after command");

   a_low_unless_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_ff != swc_pkg::SWC_OFF) |-> !power_off_out)
      else $error("power-off high outside the off state");

   a_high_while_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_ff == swc_pkg::SWC_OFF) |-> power_off_out)
      else $error("power-off low inside the off state");

   a_bad_key_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_wr && reg_addr == swc_pkg::ADDR_CTRL
       && reg_wdata[swc_pkg::KEY_LSB +: 8] != swc_pkg::CTRL_KEY
       && state_ff == swc_pkg::SWC_ON && !power_off_out) |=> state_ff == swc_pkg::SWC_ON)
      else $error("bad key write was acted on");

   a_only_key_leaves: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_ff == swc_pkg::SWC_ON && !cmd_ok) |=> state_ff == swc_pkg::SWC_ON)
      else $error("left the on state without a keyed command");

   // ==========================================================
   // Wake sources and debounce
   a_hold_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_ff == swc_pkg::SWC_OFF && !dbc_done && !security_event) |=> power_off_out)
      else $error("power-off dropped without wake");

   a_sec_wakes: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_ff == swc_pkg::SWC_OFF && security_event) |=> !power_off_out)
      else $error("security event did not wake");

   a_release_done: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_ff == swc_pkg::SWC_OFF && dbc_done) |=> !power_off_out)
      else $error("power-off not released after debounce");

   a_hit_starts_dbc: assert property (@(posedge clk_sys) disable iff (!rstn)
      any_hit |=> (dbc_run_ff && dbc_cnt_ff == 16'h0000))
      else $error("debounce did not start on edge");

   a_cnt_steps: assert property (@(posedge clk_sys) disable iff (!rstn)
      (dbc_run_ff && !dbc_done && !any_hit && !any_chg)
      |=> (dbc_run_ff && dbc_cnt_ff == $past(dbc_cnt_ff) + 16'h0001))
      else $error("debounce counter did not advance");

   a_done_stops: assert property (@(posedge clk_sys) disable iff (!rstn)
      (dbc_done && !any_hit) |=> !dbc_run_ff)
      else $error("debounce kept running after completion");

   a_dbc_written: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_wr && reg_addr == swc_pkg::ADDR_MODE)
      |=> wake_debounce_count_ff == $past(reg_wdata[swc_pkg::DBC_W-1:0]))
      else $error("debounce count not written");

   a_change_aborts: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!any_hit && any_chg && dbc_run_ff) |=> (!dbc_run_ff && dbc_cnt_ff == 16'h0000))
      else $error("debounce not cleared on new change");

   a_idle_cnt_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      !dbc_run_ff |-> dbc_cnt_ff == 16'h0000)
      else $error("stopped debounce counter not zero");

   a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
      !wake_input_enable_bit_ff[0] |-> !hit[0])
      else $error("disabled input detected");

   a_cfg_written: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_wr && reg_addr == swc_pkg::ADDR_WCFG)
      |=> wake_input_polarity_bit_ff
          == $past(reg_wdata[swc_pkg::WPOL_LSB +: swc_pkg::NUM_WAKE]))
      else $error("polarity bits not written");

   // ==========================================================
   // Status, read port and reset state
   a_status_sets: assert property (@(posedge clk_sys) disable iff (!rstn)
      hit[0] |=> wake_input_status_bit_ff[0])
      else $error("status bit missed event");

   a_all_hits_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
      (hit != 10'h000)
      |=> ((wake_input_status_bit_ff & $past(hit)) == $past(hit)))
      else $error("status lost a detected event");

   a_sec_status: assert property (@(posedge clk_sys) disable iff (!rstn)
      security_event |=> sec_status_ff)
      else $error("security status missed event");

   a_status_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_rd && reg_addr == swc_pkg::ADDR_STAT && hit == 10'h000)
      |=> wake_input_status_bit_ff == 10'h000)
      else $error("status not cleared by read");

   a_status_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
      !(reg_rd && reg_addr == swc_pkg::ADDR_STAT)
      |=> ((wake_input_status_bit_ff & $past(wake_input_status_bit_ff))
           == $past(wake_input_status_bit_ff)))
      else $error("status bit dropped without a read");

   a_status_read: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_rd && reg_addr == swc_pkg::ADDR_STAT)
      |=> reg_rdata[swc_pkg::NUM_WAKE-1:0] == $past(wake_input_status_bit_ff))
      else $error("status read returned wrong bits");

   a_reset_state: assert property (@(posedge clk_sys)
      !rstn |=> (!power_off_out && wake_input_enable_bit_ff == 10'h000 && !dbc_run_ff))
      else $error("reset state wrong");
endmodule : swc_top

// ### tb/swc_wake_model.sv
`timescale 1ns/1ps
// ==========================================================
// Push-button model: every pin rests at its level; the one at press_idx is inverted while a press lasts
module swc_wake_model (
   input  wire logic        clk_sys,
   input  wire logic [10:0] rest_lvl,
   input  wire logic [3:0]  press_idx,
   input  wire logic [7:0]  press_len,
   input  wire logic        press_go,
   output logic             dedicated_wake_pin,
   output logic [8:0]       backup_wake_pin,
   output logic             security_event
);
   logic [7:0]  left_ff;
   logic [10:0] lvl;
   initial left_ff = 8'h00;
   // A press of two cycles stands for contact bounce, shorter than the debounce count of 5 the test programs
   always @(posedge clk_sys) begin
      if (press_go) begin
         left_ff <= press_len;
      end else if (left_ff != 8'h00) begin
         left_ff <= left_ff - 8'h01;
      end
   end
   assign lvl = rest_lvl ^ ((left_ff != 8'h00) ? (11'h001 << press_idx) : 11'h000);
   assign dedicated_wake_pin = lvl[0];
   assign backup_wake_pin    = lvl[9:1];
   assign security_event     = lvl[10];
endmodule : swc_wake_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int DBC = 5;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        dedicated_wake_pin;
   logic [8:0]  backup_wake_pin;
   logic        security_event;
   logic        power_off_out;
   logic [3:0]  press_idx = 4'h0;
   logic [7:0]  press_len = 8'h00;
   logic        press_go = 1'b0;
   logic [31:0] rd_val;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n;
   logic [3:0]  t_addr [6] = '{4'h4, 4'h8, 4'h8, 4'h0, 4'h2, 4'h0};
   logic [31:0] t_wd [6] = '{32'h1234, 32'h03FF03FF, 32'h0, 32'h5A000001,
                             32'hFFFFFFFF, 32'hA5000000};
   logic [31:0] t_exp [6] = '{32'h1234, 32'h03FF03FF, 32'h0, 32'h0, 32'h0, 32'h0};

   swc_top i_swc_top (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dedicated_wake_pin(dedicated_wake_pin), .backup_wake_pin(backup_wake_pin),
      .security_event(security_event), .power_off_out(power_off_out));
   // Dedicated pin rests high so a falling polarity can be exercised
   swc_wake_model i_swc_wake_model (.clk_sys(clk_sys), .rest_lvl(11'h001),
      .press_idx(press_idx), .press_len(press_len), .press_go(press_go),
      .dedicated_wake_pin(dedicated_wake_pin), .backup_wake_pin(backup_wake_pin),
      .security_event(security_event));

   always #2.5 clk_sys = ~clk_sys;

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         $display("wrong value at %0t ns: %s", $time, msg);
         num_errors++;
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      // Read data stand only in the cycle after the strobe
      #1 rd_val = reg_rdata;
      @(posedge clk_sys);
   endtask : rd
   task automatic press(input logic [3:0] i, input logic [7:0] len);
      press_idx <= i;
      press_len <= len;
      press_go  <= 1'b1;
      @(posedge clk_sys);
      press_go <= 1'b0;
   endtask : press
   task automatic shut();
      wr(swc_pkg::ADDR_CTRL, 32'hA5000001);
      #1 check(32'(power_off_out), 32'h0, "off too early c0");
      @(posedge clk_sys);
      #1 check(32'(power_off_out), 32'h0, "off too early c1");
      @(posedge clk_sys);
      #1 check(32'(power_off_out), 32'h1, "off missing c2");
   endtask : shut
   task automatic wait_wake();
      n = 0;
      while (power_off_out !== 1'b0 && n < 40) begin
         @(posedge clk_sys);
         #1 n++;
      end
   endtask : wait_wake
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // Sized to the whole sequence with a wide margin; a hang counts as a mismatch
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         stop_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      #1 check(32'(power_off_out), 32'h0, "off after reset");
      rd(swc_pkg::ADDR_WCFG);
      check(rd_val, 32'h0, "cfg reset");
      rd(swc_pkg::ADDR_MODE);
      check(rd_val, 32'h0, "debounce reset");
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         wr(t_addr[i], t_wd[i]);
         rd(t_addr[i]);
         check(rd_val, t_exp[i], "readback row");
         // Sampled after the edge so a wrongly taken command is already visible
         #1 check(32'(power_off_out), 32'h0, "unkeyed shutdown");
      end
      $display("register rows done");
      wr(swc_pkg::ADDR_MODE, 32'(DBC));
      // One idle edge so the write strobe is never lowered and raised in one step
      @(posedge clk_sys);
      wr(swc_pkg::ADDR_WCFG, 32'h00080009);
      rd(swc_pkg::ADDR_STAT);
      shut();
      press(4'h3, 8'h02);
      repeat (20) @(posedge clk_sys);
      #1 check(32'(power_off_out), 32'h1, "short pulse woke");
      press(4'h5, 8'h1E);
      repeat (40) @(posedge clk_sys);
      #1 check(32'(power_off_out), 32'h1, "disabled pin woke");
      rd(swc_pkg::ADDR_STAT);
      check(rd_val, 32'h8, "status set");
      rd(swc_pkg::ADDR_STAT);
      check(rd_val, 32'h0, "status cleared");
      press(4'h0, 8'h1E);
      wait_wake();
      check(32'(n >= DBC && n <= DBC + 4), 32'h1, "debounce wake time");
      rd(swc_pkg::ADDR_STAT);
      check(rd_val, 32'h1, "falling on pin 0");
      $display("debounce test done");
      repeat (40) @(posedge clk_sys);
      shut();
      press(4'hA, 8'h01);
      wait_wake();
      check(32'(n <= 4), 32'h1, "security wake");
      rd(swc_pkg::ADDR_STAT);
      check(rd_val, 32'h00010000, "security status");
      shut();
      rstn <= 1'b0;
      @(posedge clk_sys);
      rstn <= 1'b1;
      #1 check(32'(power_off_out), 32'h0, "off held in reset");
      rd(swc_pkg::ADDR_WCFG);
      check(rd_val, 32'h0, "cfg after reset");
      $display("wake and reset test done");
      stop_test();
   end
endmodule : testbench
